// File: core/ain_pkg.sv
/*
 Package for the analogue input conditioner: register map, field codes, reset
 values, timing constants and the carrier structs shared by the design and the bench.
 Assumes a single 20 MHz control clock and an Avalon-MM register master.
*/
package ain_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned FILT_STEP_NS  = 1_000_000;
	localparam int unsigned FILT_STEP_CYC = FILT_STEP_NS / CLK_PERIOD_NS;
	localparam int unsigned DIV_STEPS     = 48;
	localparam int unsigned FRAC_BITS     = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_FUNC      = 8'h00;
	localparam logic [7:0] OFS_RANGE     = 8'h04;
	localparam logic [7:0] OFS_SPAN_LO   = 8'h08;
	localparam logic [7:0] OFS_SPAN_HI   = 8'h0C;
	localparam logic [7:0] OFS_LO_SEL    = 8'h10;
	localparam logic [7:0] OFS_HI_SEL    = 8'h14;
	localparam logic [7:0] OFS_USER_LO   = 8'h18;
	localparam logic [7:0] OFS_USER_HI   = 8'h1C;
	localparam logic [7:0] OFS_TC        = 8'h20;
	localparam logic [7:0] OFS_GATE      = 8'h24;
	localparam logic [7:0] OFS_GATE_WHEN_LOW_FN  = 8'h28;
	localparam logic [7:0] OFS_STATUS    = 8'h2C;
	localparam logic [7:0] OFS_VALUE     = 8'h30;
	localparam logic [7:0] OFS_SAMPLE    = 8'h34;

	// Input function codes
	localparam logic [1:0] FUNC_OFF     = 2'h0;
	localparam logic [1:0] FUNC_PROCESS = 2'h3;

	// Range codes
	localparam logic [2:0] RNG_4_20MA  = 3'h0;
	localparam logic [2:0] RNG_0_20MA  = 3'h1;
	localparam logic [2:0] RNG_USER_MA = 3'h2;
	localparam logic [2:0] RNG_0_10V   = 3'h4;
	localparam logic [2:0] RNG_2_10V   = 3'h5;
	localparam logic [2:0] RNG_USER_V  = 3'h6;

	// Physical values: current in 10 uA steps, voltage in 1 mV steps
	localparam logic [15:0] CUR_FULL       = 16'h07D0;
	localparam logic [15:0] CUR_LIVE_ZERO  = 16'h0190;
	localparam logic [15:0] VOLT_FULL      = 16'h2710;
	localparam logic [15:0] VOLT_LIVE_ZERO = 16'h07D0;
	localparam logic [15:0] PHYS_ZERO      = 16'h0000;

	// Scaled endpoint selector codes and process values in thousandths
	localparam logic [1:0]         SEL_MIN      = 2'h0;
	localparam logic [1:0]         SEL_MAX      = 2'h1;
	localparam logic [1:0]         SEL_USER     = 2'h2;
	localparam logic signed [31:0] USER_LIMIT   = 32'sh0098_9680;
	localparam logic signed [31:0] FUNC_MIN_VAL = 32'sh0000_0000;
	localparam logic signed [31:0] FUNC_MAX_VAL = 32'sh0001_86A0;

	// Filter time constant in ms
	localparam logic [13:0] TC_MIN_MS     = 14'h0001;
	localparam logic [13:0] TC_MAX_MS     = 14'h2710;
	localparam logic [13:0] TC_DEFAULT_MS = 14'h0064;

	// Gating modes and the digital input function that feeds them
	localparam logic [1:0] GATE_ALWAYS  = 2'h0;
	localparam logic [1:0] GATE_LOW     = 2'h1;
	localparam logic [1:0] GATE_HIGH    = 2'h2;
	localparam logic [4:0] GATE_WHEN_LOW_SELECT = 5'h0B;
	localparam int unsigned GATE_WHEN_LOW_COUNT = 4;

	typedef enum logic [1:0] {PH_IDLE, PH_SCALE, PH_FILT} phase_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} av_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} av_rsp_t;

	typedef struct packed {
		logic signed [31:0] cmp_value;
		logic               cmp_valid;
		logic signed [31:0] disp_value;
		logic               disp_valid;
		logic               input_active;
	} ain_out_t;

endpackage

// File: core/analog_input_conditioner.sv
/*
 Analogue input conditioner: range selection, span scaling, first-order filter
 and digital-input gating of one converted sensor signal, with an Avalon-MM
 register slave. Assumes the converter delivers sample_in with a one-cycle
 sample_valid on sys_clk; jumper and digital inputs are asynchronous pins.
*/
// Functional notes
// - Function code 0 inactive, 3 process value
// - Comparator value delivered even when function off
// - Range 0: 4-20 mA live zero, default
// - Range 5: 2-10 V live zero
// - Range 1: 0-20 mA, range 4: 0-10 V
// - Ranges 2 and 6 use user span limits
// - Jumper restricts range codes to its kind
// - Span unit follows selected range kind
// - Span low user-only, limited, default 0V/4mA
// - Span high user-only, limited, default 10V/20mA
// - Low above high inverts the characteristic
// - Low selector codes 0/1/2, default 0
// - High selector codes 0/1/2, default 1
// - User values gated, +-10000.000, default zero
// - First-order lag filter, 63 percent per T
// - Time constant 0.001 to 10 s, default 0.1
// - Gating: always, digital low, digital high
// - Digital input code 11 feeds gate select
`timescale 1ns/1ps
module analog_input_conditioner
	import ain_pkg::*;
#(
	parameter int unsigned FILT_STEP_CYCLES = ain_pkg::FILT_STEP_CYC
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// Register bus
	input  wire ain_pkg::av_req_t  av_req,
	output ain_pkg::av_rsp_t       av_rsp,
	// Converter and pins
	input  wire logic [15:0]       sample_in,
	input  wire logic              sample_valid,
	input  wire logic              current_voltage_jumper,
	input  wire logic [3:0]        gate_when_low_pins,
	// Conditioned value
	output ain_pkg::ain_out_t      ain_out
);
	import ain_pkg::*;

	typedef struct packed {
		logic [1:0]         input_function_select;
		logic [2:0]         input_range_select;
		logic [15:0]        physical_span_low;
		logic [15:0]        physical_span_high;
		logic [1:0]         scaled_low_select;
		logic [1:0]         scaled_high_select;
		logic signed [31:0] user_scaled_low;
		logic signed [31:0] user_scaled_high;
		logic [13:0]        smoothing_time_constant;
		logic [1:0]         input_gating_mode;
		logic [19:0]        gate_when_low_fn;
		logic [2:0]         jmp_sync;
		logic               jumper_volt;
		logic [3:0]         din_s1;
		logic [3:0]         din_s2;
		logic [3:0]         din_s3;
		logic [3:0]         din_level;
		logic               ack;
		logic [31:0]        rdata;
		logic [14:0]        tick_cnt;
		logic [15:0]        raw;
		phase_t             phase;
		logic [5:0]         div_cnt;
		logic [47:0]        div_num;
		logic [23:0]        div_den;
		logic [24:0]        div_rem;
		logic               div_neg;
		logic signed [31:0] scaled;
		logic signed [47:0] acc;
		logic               valid;
		logic               active;
	} st_t;

	st_t s_r;
	st_t s_nxt;

	function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic signed [31:0] endpoint(input logic [1:0] sel,
		input logic signed [31:0] user_v);
		case (sel)
			SEL_MAX:  return FUNC_MAX_VAL;
			SEL_USER: return user_v;
			default:  return FUNC_MIN_VAL;
		endcase
	endfunction

	function automatic logic [47:0] mag(input logic signed [49:0] v);
		return (v < 0) ? 48'(-v) : 48'(v);
	endfunction

	always_comb begin
		logic               req;
		logic               sel_in;
		logic               volt;
		logic               user_rng;
		logic [15:0]        lim;
		logic [15:0]        lo;
		logic [15:0]        hi;
		logic signed [16:0] den;
		logic signed [16:0] t;
		logic signed [32:0] dv;
		logic signed [49:0] prod;
		logic signed [48:0] diff;
		logic [24:0]        rem_sh;
		logic [31:0]        wv;
		logic [31:0]        rd;
		logic signed [47:0] q;
		logic signed [31:0] new_scaled;
		logic               start;
		logic [2:0]         rng_w;
		logic [15:0]        span_w;
		logic signed [31:0] user_w;
		logic [13:0]        tc_w;
		req        = av_req.read | av_req.write;
		sel_in     = 1'b0;
		volt       = s_r.input_range_select[2];
		user_rng   = (s_r.input_range_select == RNG_USER_MA) ||
			(s_r.input_range_select == RNG_USER_V);
		lim        = volt ? VOLT_FULL : CUR_FULL;
		lo         = s_r.physical_span_low;
		hi         = s_r.physical_span_high;
		den        = '0;
		t          = '0;
		dv         = '0;
		prod       = '0;
		diff       = '0;
		rem_sh     = '0;
		wv         = '0;
		rd         = '0;
		q          = '0;
		new_scaled = '0;
		start      = 1'b0;
		rng_w      = '0;
		span_w     = '0;
		user_w     = '0;
		tc_w       = '0;
		s_nxt      = s_r;

		// Pin synchronisers: a change counts once stages two and three agree
		s_nxt.jmp_sync = {s_r.jmp_sync[1:0], current_voltage_jumper};
		if (s_r.jmp_sync[2] == s_r.jmp_sync[1]) begin
			s_nxt.jumper_volt = s_r.jmp_sync[2];
		end
		s_nxt.din_s1 = gate_when_low_pins;
		s_nxt.din_s2 = s_r.din_s1;
		s_nxt.din_s3 = s_r.din_s2;
		for (int i = 0; i < GATE_WHEN_LOW_COUNT; i++) begin
			if (s_r.din_s2[i] == s_r.din_s3[i]) begin
				s_nxt.din_level[i] = s_r.din_s3[i];
			end
			// Several inputs with the select function combine as OR
			if (s_r.gate_when_low_fn[i*5 +: 5] == GATE_WHEN_LOW_SELECT && s_r.din_level[i]) begin
				sel_in = 1'b1;
			end
		end
		case (s_r.input_gating_mode)
			GATE_LOW:  s_nxt.active = ~sel_in;
			GATE_HIGH: s_nxt.active = sel_in;
			default:   s_nxt.active = 1'b1;
		endcase

		// Effective physical span for the selected range
		case (s_r.input_range_select)
			RNG_4_20MA: begin
				lo = CUR_LIVE_ZERO;
				hi = CUR_FULL;
			end
			RNG_0_20MA: begin
				lo = PHYS_ZERO;
				hi = CUR_FULL;
			end
			RNG_0_10V: begin
				lo = PHYS_ZERO;
				hi = VOLT_FULL;
			end
			RNG_2_10V: begin
				lo = VOLT_LIVE_ZERO;
				hi = VOLT_FULL;
			end
			default: begin
				lo = s_r.physical_span_low;
				hi = s_r.physical_span_high;
			end
		endcase

		// Register slave: one wait cycle, then the answer edge
		s_nxt.ack = req & ~s_r.ack;
		case (av_req.address)
			OFS_FUNC:     rd = {30'h0, s_r.input_function_select};
			OFS_RANGE:    rd = {29'h0, s_r.input_range_select};
			OFS_SPAN_LO:  rd = {16'h0, s_r.physical_span_low};
			OFS_SPAN_HI:  rd = {16'h0, s_r.physical_span_high};
			OFS_LO_SEL:   rd = {30'h0, s_r.scaled_low_select};
			OFS_HI_SEL:   rd = {30'h0, s_r.scaled_high_select};
			OFS_USER_LO:  rd = s_r.user_scaled_low;
			OFS_USER_HI:  rd = s_r.user_scaled_high;
			OFS_TC:       rd = {18'h0, s_r.smoothing_time_constant};
			OFS_GATE:     rd = {30'h0, s_r.input_gating_mode};
			OFS_GATE_WHEN_LOW_FN: rd = {12'h0, s_r.gate_when_low_fn};
			OFS_STATUS:   rd = {26'h0, (lo > hi), s_r.active, volt, s_r.jumper_volt,
				s_r.valid, s_r.valid && (s_r.input_function_select == FUNC_PROCESS)};
			OFS_VALUE:    rd = s_r.acc[47:16];
			OFS_SAMPLE:   rd = {16'h0, s_r.raw};
			default:      rd = 32'h0000_0000;
		endcase
		if (av_req.read && req && !s_r.ack) begin
			s_nxt.rdata = rd;
		end
		if (av_req.write && s_r.ack) begin
			wv     = wmerge(rd, av_req.writedata, av_req.byteenable);
			rng_w  = wv[2:0];
			span_w = wv[15:0];
			user_w = wv;
			tc_w   = wv[13:0];
			case (av_req.address)
				OFS_FUNC: begin
					if (wv[1:0] == FUNC_OFF || wv[1:0] == FUNC_PROCESS) begin
						s_nxt.input_function_select = wv[1:0];
					end
				end
				OFS_RANGE: begin
					// Only codes matching the jumper are taken; a change of kind
					// reloads the span defaults of the new unit
					if ((!s_r.jumper_volt && rng_w <= RNG_USER_MA) ||
						(s_r.jumper_volt && rng_w >= RNG_0_10V && rng_w <= RNG_USER_V)) begin
						s_nxt.input_range_select = rng_w;
						if (rng_w[2] != volt) begin
							s_nxt.physical_span_low  = rng_w[2] ? PHYS_ZERO : CUR_LIVE_ZERO;
							s_nxt.physical_span_high = rng_w[2] ? VOLT_FULL : CUR_FULL;
						end
					end
				end
				OFS_SPAN_LO: begin
					if (user_rng && span_w <= lim) begin
						s_nxt.physical_span_low = span_w;
					end
				end
				OFS_SPAN_HI: begin
					if (user_rng && span_w <= lim) begin
						s_nxt.physical_span_high = span_w;
					end
				end
				OFS_LO_SEL: begin
					if (wv[1:0] <= SEL_USER) begin
						s_nxt.scaled_low_select = wv[1:0];
					end
				end
				OFS_HI_SEL: begin
					if (wv[1:0] <= SEL_USER) begin
						s_nxt.scaled_high_select = wv[1:0];
					end
				end
				OFS_USER_LO: begin
					if (s_r.scaled_low_select == SEL_USER && user_w <= USER_LIMIT &&
						user_w >= -USER_LIMIT) begin
						s_nxt.user_scaled_low = user_w;
					end
				end
				OFS_USER_HI: begin
					if (s_r.scaled_high_select == SEL_USER && user_w <= USER_LIMIT &&
						user_w >= -USER_LIMIT) begin
						s_nxt.user_scaled_high = user_w;
					end
				end
				OFS_TC: begin
					if (tc_w >= TC_MIN_MS && tc_w <= TC_MAX_MS) begin
						s_nxt.smoothing_time_constant = tc_w;
					end
				end
				OFS_GATE: begin
					if (wv[1:0] <= GATE_HIGH) begin
						s_nxt.input_gating_mode = wv[1:0];
					end
				end
				OFS_GATE_WHEN_LOW_FN: s_nxt.gate_when_low_fn = wv[19:0];
				default: ;
			endcase
		end

		// Samples are only taken while gated on; otherwise the value freezes
		if (!s_r.active) begin
			s_nxt.valid = 1'b0;
		end else if (sample_valid) begin
			s_nxt.raw = sample_in;
		end
		if (s_r.tick_cnt == 15'(FILT_STEP_CYCLES - 1)) begin
			s_nxt.tick_cnt = '0;
			start          = s_r.active;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 15'h0001;
		end

		// Interpolation operands, clamped to the span, sign of den handles inversion
		den = $signed({1'b0, hi}) - $signed({1'b0, lo});
		t   = $signed({1'b0, s_r.raw}) - $signed({1'b0, lo});
		if (den >= 0) begin
			t = (t < 0) ? 17'sh0 : ((t > den) ? den : t);
		end else begin
			t = (t > 0) ? 17'sh0 : ((t < den) ? den : t);
		end
		dv   = 33'(endpoint(s_r.scaled_high_select, s_r.user_scaled_high)) -
			33'(endpoint(s_r.scaled_low_select, s_r.user_scaled_low));
		prod = 50'(t) * 50'(dv);

		// Shared restoring divider, one quotient bit per cycle
		rem_sh = {s_r.div_rem[23:0], s_r.div_num[47]};
		q      = s_r.div_neg ? -$signed(s_r.div_num) : $signed(s_r.div_num);
		case (s_r.phase)
			PH_IDLE: begin
				if (start) begin
					s_nxt.phase   = PH_SCALE;
					s_nxt.div_cnt = '0;
					s_nxt.div_rem = '0;
					s_nxt.div_num = mag(prod);
					s_nxt.div_den = {8'h0, (den < 0) ? 16'(-den) : 16'(den)};
					s_nxt.div_neg = (prod < 0) ^ (den < 0);
				end
			end
			PH_SCALE, PH_FILT: begin
				if (s_r.div_cnt != 6'(DIV_STEPS)) begin
					s_nxt.div_cnt = s_r.div_cnt + 6'h01;
					if (rem_sh >= {1'b0, s_r.div_den}) begin
						s_nxt.div_rem = rem_sh - {1'b0, s_r.div_den};
						s_nxt.div_num = {s_r.div_num[46:0], 1'b1};
					end else begin
						s_nxt.div_rem = rem_sh;
						s_nxt.div_num = {s_r.div_num[46:0], 1'b0};
					end
				end else if (s_r.phase == PH_SCALE) begin
					// A zero-width span holds the low endpoint
					new_scaled = endpoint(s_r.scaled_low_select, s_r.user_scaled_low);
					if (s_r.div_den != '0) begin
						new_scaled = new_scaled + q[31:0];
					end
					s_nxt.scaled  = new_scaled;
					diff          = $signed({new_scaled, 16'h0000}) - 49'(s_r.acc);
					s_nxt.phase   = PH_FILT;
					s_nxt.div_cnt = '0;
					s_nxt.div_rem = '0;
					s_nxt.div_num = mag(50'(diff));
					s_nxt.div_den = {10'h0, s_r.smoothing_time_constant};
					s_nxt.div_neg = diff < 0;
				end else begin
					// Step of (x - y) * dt / T with dt of one ms gives the exponential lag;
					// a gate that closed mid-computation discards the step
					if (s_r.active) begin
						s_nxt.acc = s_r.acc + q;
					end
					s_nxt.valid = s_r.active;
					s_nxt.phase = PH_IDLE;
				end
			end
			default: s_nxt.phase = PH_IDLE;
		endcase

		if (!rst_b) begin
			s_nxt                         = '0;
			s_nxt.input_function_select   = FUNC_PROCESS;
			s_nxt.input_range_select      = RNG_4_20MA;
			s_nxt.physical_span_low       = CUR_LIVE_ZERO;
			s_nxt.physical_span_high      = CUR_FULL;
			s_nxt.scaled_low_select       = SEL_MIN;
			s_nxt.scaled_high_select      = SEL_MAX;
			s_nxt.smoothing_time_constant = TC_DEFAULT_MS;
			s_nxt.input_gating_mode       = GATE_ALWAYS;
			s_nxt.phase                   = PH_IDLE;
			s_nxt.active                  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_r <= s_nxt;
	end

	assign av_rsp.readdata    = s_r.rdata;
	assign av_rsp.waitrequest = (av_req.read | av_req.write) & ~s_r.ack;

	// Comparators always see the conditioned value, whatever the function code
	assign ain_out.cmp_value    = s_r.acc[47:16];
	assign ain_out.cmp_valid    = s_r.valid;
	assign ain_out.disp_value   = s_r.acc[47:16];
	assign ain_out.disp_valid   = s_r.valid && (s_r.input_function_select == FUNC_PROCESS);
	assign ain_out.input_active = s_r.active;

endmodule

// File: tb/ain_chk.sv
/*
 Port checker for the analogue input conditioner, bound to its top module.
 Assumes one clock, synchronous active-low reset and a master that holds requests.
*/
`timescale 1ns/1ps
module ain_chk
	import ain_pkg::*;
#(
	parameter int unsigned FILT_STEP_CYCLES = ain_pkg::FILT_STEP_CYC
) (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst_b,
	// Register bus
	input wire ain_pkg::av_req_t  av_req,
	input wire ain_pkg::av_rsp_t  av_rsp,
	// Converter and pins
	input wire logic [15:0]       sample_in,
	input wire logic              sample_valid,
	input wire logic              current_voltage_jumper,
	input wire logic [3:0]        gate_when_low_pins,
	// Conditioned value
	input wire ain_pkg::ain_out_t ain_out
);
	wire rq = av_req.read | av_req.write;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	property p_wait_first;
		rq && !$past(rq) |-> av_rsp.waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait cycle on new request");
	property p_wait_one;
		rq && av_rsp.waitrequest |=> !av_rsp.waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
	property p_wait_idle;
		!rq |-> !av_rsp.waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
	// Read data must not drift between captures
	property p_rd_hold;
		!(av_req.read && av_rsp.waitrequest) |=> $stable(av_rsp.readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("readdata changed without read");
	property p_disp_same;
		ain_out.disp_value == ain_out.cmp_value;
	endproperty
	a_disp_same: assert property (p_disp_same) else $error("display and compare differ");
	property p_disp_valid;
		ain_out.disp_valid |-> ain_out.cmp_valid;
	endproperty
	a_disp_valid: assert property (p_disp_valid) else $error("display valid alone");
	property p_off_invalid;
		!ain_out.input_active |=> !ain_out.cmp_valid;
	endproperty
	a_off_invalid: assert property (p_off_invalid) else $error("valid while gated off");
	property p_chg_valid;
		$changed(ain_out.cmp_value) |-> ain_out.cmp_valid;
	endproperty
	a_chg_valid: assert property (p_chg_valid) else $error("value moved while invalid");
	property p_rst_vals;
		$rose(rst_b) |-> !ain_out.cmp_valid && ain_out.input_active && ain_out.cmp_value == 0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");

	c_valid: cover property ($rose(ain_out.cmp_valid));
	c_gate_off: cover property ($fell(ain_out.input_active));
	c_write: cover property (av_req.write && !av_rsp.waitrequest);
	c_read: cover property (av_req.read && !av_rsp.waitrequest);
endmodule

bind analog_input_conditioner ain_chk #(.FILT_STEP_CYCLES(FILT_STEP_CYCLES)) ain_chk_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
	.sample_in(sample_in), .sample_valid(sample_valid),
	.current_voltage_jumper(current_voltage_jumper), .gate_when_low_pins(gate_when_low_pins),
	.ain_out(ain_out));

// File: tb/sensor_model.sv
/*
 Converter and sensor stand-in: a one-cycle sample strobe every GAP cycles.
 Assumes the bench sets the sensor level; outside a strobe the data lines scramble.
*/
`timescale 1ns/1ps
module sensor_model #(
	parameter int GAP = 50
) (
	input  wire logic        clk,
	input  wire logic [15:0] level,
	output logic [15:0]      sample_in = 16'h0000,
	output logic             sample_valid = 1'b0
);
	int cnt = 0;

	// Inverted data between strobes so a stale value cannot pass by luck
	always @(posedge clk) begin
		cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
		sample_valid <= (cnt == 0);
		sample_in <= (cnt == 0) ? level : ~level;
	end
endmodule

// File: tb/tb_top.sv
/*
 Self-checking bench for the analogue input conditioner.
 Assumes a 200-cycle filter step so one millisecond of filter time stays short.
*/
`timescale 1ns/1ps
module tb_top;
	import ain_pkg::*;
	localparam int unsigned STEP = 200;
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        jmp     = 1'b0;
	logic [3:0]  pins    = 4'h0;
	logic [15:0] level   = 16'h0000;
	logic [15:0] smp;
	logic        sv;
	av_req_t     req     = '0;
	av_rsp_t     rsp;
	ain_out_t    ao;
	int          fails   = 0;
	int          checked = 0;
	logic [31:0] rdv;

	always #25 sys_clk = ~sys_clk;

	sensor_model #(.GAP(50)) sensor_model_i (.clk(sys_clk), .level(level), .sample_in(smp),
		.sample_valid(sv));
	analog_input_conditioner #(.FILT_STEP_CYCLES(STEP)) analog_input_conditioner_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .av_req(req), .av_rsp(rsp), .sample_in(smp),
		.sample_valid(sv), .current_voltage_jumper(jmp), .gate_when_low_pins(pins), .ain_out(ao));

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", n, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (rsp.waitrequest === 1'b0) begin
				rdv = rsp.readdata;
				req <= '0;
				return;
			end
		end
		chk("waitrequest", 32'h1, 32'h0);
		stop_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %0h", a), rdv, e);
	endtask

	// Waits on the value (sel 0), the gate result (sel 1) or the valid flag (sel 2)
	task automatic wt(input int sel, input logic [31:0] e);
		logic [31:0] v;
		string       n;
		if (sel == 0) begin
			n = "cmp_value";
		end else if (sel == 1) begin
			n = "input_active";
		end else begin
			n = "cmp_valid";
		end
		for (int i = 0; i < 900; i++) begin
			@(posedge sys_clk);
			if (sel == 0) begin
				v = ao.cmp_value;
			end else begin
				v = {31'h0, (sel == 1) ? ao.input_active : ao.cmp_valid};
			end
			if (v === e) break;
		end
		chk(n, v, e);
		if (v !== e) stop_test();
	endtask

	task automatic t_defaults();
		logic [7:0]  a[12] = '{OFS_FUNC, OFS_RANGE, OFS_SPAN_LO, OFS_SPAN_HI, OFS_LO_SEL,
			OFS_HI_SEL, OFS_USER_LO, OFS_USER_HI, OFS_TC, OFS_GATE, OFS_GATE_WHEN_LOW_FN, 8'h3C};
		logic [31:0] e[12] = '{32'h3, 32'h0, 32'h190, 32'h7D0, 32'h0, 32'h1, 32'h0, 32'h0,
			32'h64, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 12; i++) rc(a[i], e[i]);
	endtask

	task automatic t_refuse();
		wr(OFS_FUNC, 32'h1);
		rc(OFS_FUNC, 32'h3);
		wr(OFS_RANGE, 32'h4);
		rc(OFS_RANGE, 32'h0);
		wr(OFS_SPAN_LO, 32'h64);
		rc(OFS_SPAN_LO, 32'h190);
		wr(OFS_USER_LO, 32'h5);
		rc(OFS_USER_LO, 32'h0);
		wr(OFS_GATE, 32'h3);
		rc(OFS_GATE, 32'h0);
	endtask

	task automatic t_scale();
		wr(OFS_TC, 32'h1);
		wr(OFS_RANGE, 32'h1);
		level <= 16'h03E8;
		wt(0, 32'hC350);
		chk("disp_value", ao.disp_value, 32'hC350);
		rc(OFS_VALUE, 32'hC350);
		rc(OFS_SAMPLE, 32'h3E8);
		wr(OFS_RANGE, 32'h0);
		level <= 16'h0320;
		wt(0, 32'h61A8);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("unit", {31'h0, rdv[3]}, 32'h0);
	endtask

	task automatic t_user();
		wr(OFS_RANGE, 32'h2);
		wr(OFS_SPAN_LO, 32'h9C4);
		rc(OFS_SPAN_LO, 32'h190);
		wr(OFS_SPAN_LO, 32'h320);
		wr(OFS_SPAN_HI, 32'h190);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("inverted", {31'h0, rdv[5]}, 32'h1);
		wr(OFS_LO_SEL, 32'h1);
		wr(OFS_HI_SEL, 32'h2);
		wr(OFS_USER_HI, 32'h4E20);
		rc(OFS_USER_HI, 32'h4E20);
		level <= 16'h01F4;
		wt(0, 32'h9C40);
		wr(OFS_LO_SEL, 32'h0);
		wr(OFS_HI_SEL, 32'h1);
	endtask

	task automatic t_volt();
		@(posedge sys_clk);
		jmp <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rc(OFS_RANGE, 32'h2);
		wr(OFS_RANGE, 32'h1);
		rc(OFS_RANGE, 32'h2);
		wr(OFS_RANGE, 32'h5);
		rc(OFS_RANGE, 32'h5);
		rc(OFS_SPAN_HI, 32'h2710);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("unit", {31'h0, rdv[3]}, 32'h1);
		level <= 16'h1770;
		wt(0, 32'hC350);
		wr(OFS_RANGE, 32'h4);
		level <= 16'h09C4;
		wt(0, 32'h61A8);
		wr(OFS_RANGE, 32'h6);
		wr(OFS_SPAN_HI, 32'h2711);
		rc(OFS_SPAN_HI, 32'h2710);
		wr(OFS_SPAN_LO, 32'h1388);
		level <= 16'h1D4C;
		wt(0, 32'hC350);
	endtask

	task automatic t_gate();
		logic [31:0] v0;
		wr(OFS_GATE_WHEN_LOW_FN, 32'h2C00);
		wr(OFS_GATE, 32'h2);
		wt(1, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk("cmp_valid", {31'h0, ao.cmp_valid}, 32'h0);
		v0 = ao.cmp_value;
		level <= 16'h0000;
		repeat (2 * STEP + 150) @(posedge sys_clk);
		chk("frozen", ao.cmp_value, v0);
		pins <= 4'h4;
		wt(1, 32'h1);
		wt(0, 32'h0);
		wr(OFS_GATE, 32'h1);
		wt(1, 32'h0);
		pins <= 4'h0;
		wt(1, 32'h1);
		wr(OFS_GATE, 32'h0);
	endtask

	task automatic t_func();
		wt(2, 32'h1);
		wr(OFS_FUNC, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("disp_valid", {31'h0, ao.disp_valid}, 32'h0);
		chk("cmp_valid", {31'h0, ao.cmp_valid}, 32'h1);
		wr(OFS_FUNC, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk("disp_valid", {31'h0, ao.disp_valid}, 32'h1);
	endtask

	// Four steps of a four-millisecond lag give 68 percent, five give 76
	task automatic t_lag();
		logic signed [31:0] v;
		wr(OFS_TC, 32'h4);
		level <= 16'h2710;
		repeat (4 * STEP + 150) @(posedge sys_clk);
		v = ao.cmp_value;
		chk("lag", {31'h0, v >= 63000 && v < 100000}, 32'h1);
		wr(OFS_TC, 32'h0);
		rc(OFS_TC, 32'h4);
		wr(OFS_TC, 32'h2711);
		rc(OFS_TC, 32'h4);
		wr(OFS_TC, 32'h2710);
		rc(OFS_TC, 32'h2710);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_defaults();
		t_refuse();
		t_scale();
		t_user();
		t_volt();
		t_gate();
		t_func();
		t_lag();
		stop_test();
	end
endmodule
